/* File: design/acdc_clock_config.sv */
// Chosen here: register access over APB.
`timescale 1ns/1ps

// What this block does
// - Multiplier: 14 bits, six high, eight low
// - Multiplier high byte waits for low write
// - First divider bit 7 powers it up
// - First divider ratio 7 bits, zero means 128
// - Second divider bit 7 powers it up
// - Second divider ratio 7 bits, zero means 128
// - Oversampling 10 bits, zero means 1024
// - Oversampling high waits for low write
// - Reserved bits and registers read zero
module acdc_clock_config (
  input  wire logic        core_clk_in,                 // 50 MHz control clock
  input  wire logic        resetn_in,                   // Async reset, low
  input  wire logic        psel_in,                     // APB select
  input  wire logic        penable_in,                  // APB access phase
  input  wire logic        pwrite_in,                   // APB direction
  input  wire logic [7:0]  paddr_in,                    // APB byte address
  input  wire logic [31:0] pwdata_in,                   // APB write data
  output logic      [31:0] prdata_out,                  // APB read data
  output logic             pready_out,                  // APB ready
  output logic             pslverr_out,                 // APB error
  output logic      [13:0] pll_frac_value_out,          // Multiplier value
  output logic             pll_frac_range_err_out,      // Multiplier > limit
  output logic             dac_first_divider_power_out, // First divider on
  output logic      [7:0]  dac_first_divider_ratio_out, // 1..128
  output logic             dac_second_divider_power_out,// Second divider on
  output logic      [7:0]  dac_second_divider_ratio_out,// 1..128
  output logic      [10:0] dac_oversample_ratio_out     // 1..1024
);

  // ========================================================================
  // Decode helpers
  // ========================================================================

  // Seven-bit divider code to its ratio; code zero is the top ratio
  function automatic logic [7:0] div_ratio(input logic [6:0] code);
    logic [7:0] r;
    r = (code == 7'h00) ? acdc_pkg::DIV_ZERO_RATIO : {1'b0, code};
    return r;
  endfunction

  // Ten-bit oversampling code to its ratio; code zero is the top ratio
  function automatic logic [10:0] osr_ratio(input logic [9:0] code);
    logic [10:0] r;
    r = (code == 10'h000) ? acdc_pkg::OSR_ZERO_RATIO : {1'b0, code};
    return r;
  endfunction

  // ========================================================================
  // APB decode
  // ========================================================================
  logic [5:0] word_idx;       // Word index of the request
  logic       addr_aligned;   // Low address bits clear
  logic       idx_mapped;     // Index inside the register window
  logic       addr_ok;        // Usable address
  logic       setup_phase;    // First cycle of a transfer
  logic       access_done;    // Transfer completes at this edge
  logic       wr_fire;        // Completed write
  logic       wr_ok;          // Completed write to a mapped word

  // Index is the byte address over four
  assign word_idx     = paddr_in[7:2];
  assign addr_aligned = (paddr_in[1:0] == 2'b00);
  assign idx_mapped   = (word_idx >= acdc_pkg::IDX_PLL_FRAC_HIGH) &&
                        (word_idx <= acdc_pkg::IDX_STATUS);
  assign addr_ok      = addr_aligned && idx_mapped;

  // Ready is registered, so every access is setup plus one access cycle
  assign setup_phase  = psel_in && !penable_in;
  assign access_done  = psel_in && penable_in && pready_out;
  assign wr_fire      = access_done && pwrite_in;
  assign wr_ok        = wr_fire && addr_ok;

  // ========================================================================
  // Write strobes per register
  // ========================================================================
  logic wr_pll_high;   // Multiplier high byte
  logic wr_pll_low;    // Multiplier low byte
  logic wr_div1;       // First divider
  logic wr_div2;       // Second divider
  logic wr_osr_high;   // Oversampling high bits
  logic wr_osr_low;    // Oversampling low byte
  logic wr_not_pll;    // Write that breaks the multiplier pair
  logic wr_not_osr;    // Write that breaks the oversampling pair

  assign wr_pll_high = wr_ok && (word_idx == acdc_pkg::IDX_PLL_FRAC_HIGH);
  assign wr_pll_low  = wr_ok && (word_idx == acdc_pkg::IDX_PLL_FRAC_LOW);
  assign wr_div1     = wr_ok && (word_idx == acdc_pkg::IDX_DAC_FIRST_DIV);
  assign wr_div2     = wr_ok && (word_idx == acdc_pkg::IDX_DAC_SECOND_DIV);
  assign wr_osr_high = wr_ok && (word_idx == acdc_pkg::IDX_DAC_OSR_HIGH);
  assign wr_osr_low  = wr_ok && (word_idx == acdc_pkg::IDX_DAC_OSR_LOW);

  // Every completed write counts as a command, even to reserved or
  // unmapped words, so a stray access cannot sneak a stale high part in
  assign wr_not_pll  = wr_fire && !wr_pll_high && !wr_pll_low;
  assign wr_not_osr  = wr_fire && !wr_osr_high && !wr_osr_low;

  // ========================================================================
  // Paired registers
  // ========================================================================
  logic [13:0] pll_frac_value;   // Committed multiplier
  logic        pll_pending;      // Multiplier high staged
  logic [9:0]  osr_value;        // Committed oversampling code
  logic        osr_pending;      // Oversampling high staged

  // Multiplier: high part held until the very next write is the low one
  acdc_pair_commit #(
    .HIGH_W    (acdc_pkg::PLL_HIGH_W),
    .LOW_RESET (acdc_pkg::RST_PLL_FRAC_LOW)
  ) u_pll_frac (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .wr_high_in  (wr_pll_high),
    .wr_low_in   (wr_pll_low),
    .wr_other_in (wr_not_pll),
    .wdata_in    (pwdata_in[7:0]),
    .value_out   (pll_frac_value),
    .pending_out (pll_pending)
  );

  // Oversampling: same deferred commit on a two-bit high part
  acdc_pair_commit #(
    .HIGH_W    (acdc_pkg::OSR_HIGH_W),
    .LOW_RESET (acdc_pkg::RST_DAC_OSR_LOW)
  ) u_dac_osr (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .wr_high_in  (wr_osr_high),
    .wr_low_in   (wr_osr_low),
    .wr_other_in (wr_not_osr),
    .wdata_in    (pwdata_in[7:0]),
    .value_out   (osr_value),
    .pending_out (osr_pending)
  );

  // ========================================================================
  // Divider registers
  // ========================================================================
  logic [7:0] dac_first_divider_reg;    // Power bit and ratio code
  logic [7:0] dac_first_divider_next;
  logic [7:0] dac_second_divider_reg;   // Power bit and ratio code
  logic [7:0] dac_second_divider_next;

  // Dividers take effect at once; no pairing on single bytes
  assign dac_first_divider_next  = wr_div1 ? pwdata_in[7:0]
                                           : dac_first_divider_reg;
  assign dac_second_divider_next = wr_div2 ? pwdata_in[7:0]
                                           : dac_second_divider_reg;

  // Divider storage
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dac_first_divider_reg  <= acdc_pkg::RST_DAC_DIV;
      dac_second_divider_reg <= acdc_pkg::RST_DAC_DIV;
    end else begin
      dac_first_divider_reg  <= dac_first_divider_next;
      dac_second_divider_reg <= dac_second_divider_next;
    end
  end

  // ========================================================================
  // Clock tree outputs
  // ========================================================================
  logic        pll_range_err;      // Forbidden multiplier encoding
  logic [7:0]  div1_ratio;         // Decoded first ratio
  logic [7:0]  div2_ratio;         // Decoded second ratio
  logic [10:0] osr_ratio_dec;      // Decoded oversampling ratio

  // Hardware passes the value on; a forbidden code is only flagged
  assign pll_range_err = (pll_frac_value > acdc_pkg::PLL_FRAC_MAX);
  assign div1_ratio    = div_ratio(dac_first_divider_reg[6:0]);
  assign div2_ratio    = div_ratio(dac_second_divider_reg[6:0]);
  assign osr_ratio_dec = osr_ratio(osr_value);

  // Outputs are re-registered, so they trail the register by one edge
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_frac_value_out           <= '0;
      pll_frac_range_err_out       <= 1'b0;
      dac_first_divider_power_out  <= 1'b0;
      dac_first_divider_ratio_out  <= 8'h01;
      dac_second_divider_power_out <= 1'b0;
      dac_second_divider_ratio_out <= 8'h01;
      dac_oversample_ratio_out     <= 11'h080;
    end else begin
      pll_frac_value_out           <= pll_frac_value;
      pll_frac_range_err_out       <= pll_range_err;
      dac_first_divider_power_out  <=
        dac_first_divider_reg[acdc_pkg::DIV_POWER_BIT];
      dac_first_divider_ratio_out  <= div1_ratio;
      dac_second_divider_power_out <=
        dac_second_divider_reg[acdc_pkg::DIV_POWER_BIT];
      dac_second_divider_ratio_out <= div2_ratio;
      dac_oversample_ratio_out     <= osr_ratio_dec;
    end
  end

  // ========================================================================
  // Read mux
  // ========================================================================
  logic [7:0]  status_byte;   // Pending flags and range flag
  logic [7:0]  rd_byte;       // Selected register byte
  logic [31:0] rd_word;       // Zero-extended read data

  // Live state for software; reads never disturb a staged pair
  assign status_byte = {5'b0_0000, pll_range_err, osr_pending, pll_pending};

  // Reads show committed values; upper unused bits stay zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (word_idx)
      acdc_pkg::IDX_PLL_FRAC_HIGH:
        rd_byte = {2'b00, pll_frac_value[13:8]};
      acdc_pkg::IDX_PLL_FRAC_LOW:
        rd_byte = pll_frac_value[7:0];
      acdc_pkg::IDX_DAC_FIRST_DIV:
        rd_byte = dac_first_divider_reg;
      acdc_pkg::IDX_DAC_SECOND_DIV:
        rd_byte = dac_second_divider_reg;
      acdc_pkg::IDX_DAC_OSR_HIGH:
        rd_byte = {6'b00_0000, osr_value[9:8]};
      acdc_pkg::IDX_DAC_OSR_LOW:
        rd_byte = osr_value[7:0];
      acdc_pkg::IDX_STATUS:
        rd_byte = status_byte;
      default:
        rd_byte = 8'h00;   // Reserved words nine and ten
    endcase
  end

  // Bits above the byte read as zero
  assign rd_word = addr_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // ========================================================================
  // APB answer
  // ========================================================================
  logic        pready_next;    // Ready in the access cycle
  logic        pslverr_next;   // Error for unmapped or misaligned
  logic [31:0] prdata_next;    // Captured read data

  // Answer is prepared in the setup cycle and shown in the access cycle
  assign pready_next  = setup_phase;
  assign pslverr_next = setup_phase && !addr_ok;
  assign prdata_next  = (setup_phase && !pwrite_in) ? rd_word
                                                    : 32'h0000_0000;

  // Answer registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= pready_next;
      pslverr_out <= pslverr_next;
      prdata_out  <= prdata_next;
    end
  end

  // Writes to reserved words are accepted and dropped; they still count
  // as a command and so break a pending pair

endmodule // acdc_clock_config

/* File: design/acdc_pkg.sv */
// ==========================================================================
// Shared constants for the audio clock divider configuration block
// ==========================================================================
package acdc_pkg;

  // ========================================================================
  // Bus geometry
  // ========================================================================
  localparam int unsigned ADDR_W = 8;             // APB byte address width
  localparam int unsigned DATA_W = 32;            // APB data width
  localparam int unsigned IDX_W  = 6;             // Word index width

  // ========================================================================
  // Register indices (byte address is four times the index)
  // ========================================================================
  localparam logic [5:0] IDX_PLL_FRAC_HIGH  = 6'h07;
  localparam logic [5:0] IDX_PLL_FRAC_LOW   = 6'h08;
  localparam logic [5:0] IDX_RESERVED_NINE  = 6'h09;
  localparam logic [5:0] IDX_RESERVED_TEN   = 6'h0a;
  localparam logic [5:0] IDX_DAC_FIRST_DIV  = 6'h0b;
  localparam logic [5:0] IDX_DAC_SECOND_DIV = 6'h0c;
  localparam logic [5:0] IDX_DAC_OSR_HIGH   = 6'h0d;
  localparam logic [5:0] IDX_DAC_OSR_LOW    = 6'h0e;
  localparam logic [5:0] IDX_STATUS         = 6'h0f;

  // ========================================================================
  // Reset values
  // ========================================================================
  localparam logic [7:0] RST_PLL_FRAC_HIGH  = 8'h00;
  localparam logic [7:0] RST_PLL_FRAC_LOW   = 8'h00;
  localparam logic [7:0] RST_DAC_DIV        = 8'h01;
  localparam logic [7:0] RST_DAC_OSR_HIGH   = 8'h00;
  localparam logic [7:0] RST_DAC_OSR_LOW    = 8'h80;

  // ========================================================================
  // Field layout
  // ========================================================================
  localparam int unsigned PLL_HIGH_W     = 6;     // Multiplier upper bits
  localparam int unsigned OSR_HIGH_W     = 2;     // Oversampling upper bits
  localparam int unsigned DIV_POWER_BIT  = 7;     // Divider power control
  localparam int unsigned STAT_PLL_PEND  = 0;     // Multiplier high pending
  localparam int unsigned STAT_OSR_PEND  = 1;     // Oversampling high pending
  localparam int unsigned STAT_PLL_RANGE = 2;     // Multiplier above limit

  // ========================================================================
  // Value limits and code-zero meanings
  // ========================================================================
  localparam logic [13:0] PLL_FRAC_MAX   = 14'h270f;  // 9999
  localparam logic [7:0]  DIV_ZERO_RATIO = 8'h80;     // Code 0 means 128
  localparam logic [10:0] OSR_ZERO_RATIO = 11'h400;   // Code 0 means 1024

endpackage : acdc_pkg

/* File: design/acdc_pair_commit.sv */
`timescale 1ns/1ps

// ==========================================================================
// High/low byte pair with deferred commit of the high part
// ==========================================================================
module acdc_pair_commit #(
  parameter int unsigned HIGH_W    = 6,
  parameter logic [7:0]  LOW_RESET = 8'h00
) (
  input  wire logic                core_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                wr_high_in,   // Completed write, high reg
  input  wire logic                wr_low_in,    // Completed write, low reg
  input  wire logic                wr_other_in,  // Completed write elsewhere
  input  wire logic [7:0]          wdata_in,     // Written byte
  output logic      [HIGH_W+7:0]   value_out,    // Effective value
  output logic                     pending_out   // High part waiting
);

  // ========================================================================
  // Storage
  // ========================================================================
  logic [HIGH_W-1:0] pend_high_reg;   // Staged high part
  logic [HIGH_W-1:0] pend_high_next;
  logic              pend_valid_reg;  // Staged part still usable
  logic              pend_valid_next;
  logic [HIGH_W+7:0] value_reg;       // Committed value
  logic [HIGH_W+7:0] value_next;
  logic [HIGH_W-1:0] commit_high;     // High part used by a low write

  // Low write takes staged high only if it directly followed
  assign commit_high = pend_valid_reg ? pend_high_reg
                                      : value_reg[HIGH_W+7:8];

  // High write is only staged, never applied at once
  assign pend_high_next  = wr_high_in ? wdata_in[HIGH_W-1:0]
                                      : pend_high_reg;

  // Any write other than the high one ends the pairing window
  assign pend_valid_next = wr_high_in ? 1'b1
                         : (wr_low_in | wr_other_in) ? 1'b0
                         : pend_valid_reg;

  // Whole value moves together at the low write
  assign value_next = wr_low_in ? {commit_high, wdata_in} : value_reg;

  // State update
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_high_reg  <= '0;
      pend_valid_reg <= 1'b0;
      value_reg      <= {{HIGH_W{1'b0}}, LOW_RESET};
    end else begin
      pend_high_reg  <= pend_high_next;
      pend_valid_reg <= pend_valid_next;
      value_reg      <= value_next;
    end
  end

  assign value_out   = value_reg;
  assign pending_out = pend_valid_reg;

endmodule // acdc_pair_commit

/* File: sim/acdc_clock_config_chk.sv */
`timescale 1ns/1ps

// ==========================================================
// Port-level checks of the clock configuration block
// ==========================================================
module acdc_chk (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [13:0] pll_frac_value_out,
  input wire logic        pll_frac_range_err_out,
  input wire logic        dac_first_divider_power_out,
  input wire logic [7:0]  dac_first_divider_ratio_out,
  input wire logic        dac_second_divider_power_out,
  input wire logic [7:0]  dac_second_divider_ratio_out,
  input wire logic [10:0] dac_oversample_ratio_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Decodes of the request side
  wire setup    = psel_in & ~penable_in;
  wire wr_done  = psel_in & penable_in & pready_out & pwrite_in;
  wire bad_addr = (paddr_in[7:2] < 6'h07) | (paddr_in[7:2] > 6'h0f) | (paddr_in[1:0] != 2'b00);
  wire rsvd_rd  = setup & ~pwrite_in & ((paddr_in == 8'h24) | (paddr_in == 8'h28));
  wire wr_pll   = wr_done & (paddr_in == 8'h20);  // Low byte only commits
  wire wr_osr   = wr_done & (paddr_in == 8'h38);
  wire wr_div1  = wr_done & (paddr_in == 8'h2c);
  wire wr_div2  = wr_done & (paddr_in == 8'h30);

  property p_ready_follows; setup |=> pready_out ##1 !pready_out; endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("ready not a single pulse");
  property p_err_with_ready; pslverr_out |-> pready_out; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_err_decode; setup |=> (pslverr_out == $past(bad_addr)); endproperty
  a_err_decode: assert property (p_err_decode) else $error("error flag vs address");
  property p_rdata_idle; !pready_out |-> (prdata_out == 32'h0); endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_rsvd_read; rsvd_rd |=> (prdata_out == 32'h0) && !pslverr_out; endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word not zero");
  // Effective values may only move two edges after the write that commits them: low byte, or the divider write
  property p_pll_commit; $changed(pll_frac_value_out) |-> $past(wr_pll, 2); endproperty
  a_pll_commit: assert property (p_pll_commit) else $error("multiplier moved");
  property p_osr_commit; $changed(dac_oversample_ratio_out) |-> $past(wr_osr, 2); endproperty
  a_osr_commit: assert property (p_osr_commit) else $error("oversample moved");
  property p_div1_change;
    $changed({dac_first_divider_power_out, dac_first_divider_ratio_out}) |-> $past(wr_div1, 2);
  endproperty
  a_div1_change: assert property (p_div1_change) else $error("first divider moved");
  property p_div2_change;
    $changed({dac_second_divider_power_out, dac_second_divider_ratio_out}) |-> $past(wr_div2, 2);
  endproperty
  a_div2_change: assert property (p_div2_change) else $error("second divider moved");
  property p_ratio_range;
    dac_first_divider_ratio_out inside {[8'h01:8'h80]} &&
    dac_second_divider_ratio_out inside {[8'h01:8'h80]} &&
    dac_oversample_ratio_out inside {[11'h001:11'h400]};
  endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("bad ratio");
endmodule // acdc_chk

bind acdc_clock_config acdc_chk u_chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .pll_frac_value_out(pll_frac_value_out),
  .pll_frac_range_err_out(pll_frac_range_err_out),
  .dac_first_divider_power_out(dac_first_divider_power_out),
  .dac_first_divider_ratio_out(dac_first_divider_ratio_out),
  .dac_second_divider_power_out(dac_second_divider_power_out),
  .dac_second_divider_ratio_out(dac_second_divider_ratio_out),
  .dac_oversample_ratio_out(dac_oversample_ratio_out));

/* File: sim/acdc_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Host software model, APB master side
// ==========================================================
module acdc_host_model (
  input  wire logic        core_clk_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [7:0]  paddr_out,
  output logic      [31:0] pwdata_out
);
  // Idle bus at time zero
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'hff;
    pwdata_out  = 32'hffffffff;
  end

  // One transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge core_clk_in);
    penable_out <= 1'b1;
    // Only the bench watchdog may end a wait for ready
    do begin
      @(posedge core_clk_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    // Released lines show the inverse, never the stale value
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwrite_out  <= ~w;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask

  // High then low as back-to-back commands, defined bits only
  task automatic wr_pair(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, {24'h0, hi}, rd, err);
    xfer(1'b1, a + 8'h04, {24'h0, lo}, rd, err);
  endtask

  // Multiplier write, never above the legal limit
  task automatic wr_pll(input logic [13:0] v);
    logic [13:0] s;
    s = (v > 14'h270f) ? 14'h270f : v;
    wr_pair(8'h1c, {2'b00, s[13:8]}, s[7:0]);
  endtask

  // Oversampling ratio write
  task automatic wr_osr(input logic [9:0] v);
    wr_pair(8'h34, {6'h00, v[9:8]}, v[7:0]);
  endtask
endmodule // acdc_host_model

/* File: sim/tb_acdc_clock_config.sv */
`timescale 1ns/1ps

// ==========================================================
// Register-level bench of the clock configuration block
// ==========================================================
module tb_acdc_clock_config;
  logic        core_clk_in, resetn_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, r1, r2;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] pll;
  logic [10:0] osr;
  logic        perr, p1, p2, er;
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [7:0]  rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80};
  logic [7:0]  codes   [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
  logic [7:0]  mids    [3] = '{8'h80, 8'h24, 8'h3c};  // Unmapped, reserved, status

  // ==========================================================
  // Clock, host and design
  // ==========================================================
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  acdc_host_model HOST (.core_clk_in(core_clk_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  acdc_clock_config DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pll_frac_value_out(pll), .pll_frac_range_err_out(perr),
    .dac_first_divider_power_out(p1), .dac_first_divider_ratio_out(r1),
    .dac_second_divider_power_out(p2), .dac_second_divider_ratio_out(r2),
    .dac_oversample_ratio_out(osr));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    HOST.xfer(1'b1, a, d, rd, er);
    check(32'(er), 32'(e));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    HOST.xfer(1'b0, a, 32'h0, rd, er);
    check(rd, x);
    check(32'(er), 32'(e));
  endtask
  // Derived outputs land one edge after the register edge
  task automatic settle();
    @(posedge core_clk_in);
    #1;
  endtask
  function automatic logic [7:0] div_ratio(input logic [6:0] c);
    return (c == 7'h00) ? 8'h80 : {1'b0, c};
  endfunction
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    check(32'(pll), 32'h0);
    check(32'({perr, p1, p2, r1, r2, osr}), 32'({3'b000, 8'h01, 8'h01, 11'h080}));
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the two hundred or so cycles used
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    conclude();
  end

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    resetn_in = 1'b0;
    do_reset();
    for (int i = 0; i < 8; i++) rdc(8'h1c + 8'(4 * i), {24'h0, rst_tab[i]}, 1'b0);
    rdc(8'h1d, 32'h0, 1'b1);  // Misaligned read refused
    // Top legal multiplier, read back split
    HOST.wr_pll(14'h270f);
    settle();
    check(32'({perr, pll}), 32'h270f);
    rdc(8'h1c, 32'h27, 1'b0);
    rdc(8'h20, 32'h0f, 1'b0);
    // Staged high byte dropped by any write between
    for (int i = 0; i < 3; i++) begin
      wr(8'h1c, 32'h05, 1'b0);
      settle();
      check(32'(pll), {18'h0, 6'h27, 8'h0f - 8'(i)});
      rdc(8'h3c, 32'h1, 1'b0);
      rdc(8'h1c, 32'h27, 1'b0);
      wr(mids[i], 32'h0, (i == 0));
      wr(8'h20, 32'h0e - 32'(i), 1'b0);
      settle();
      check(32'(pll), {18'h0, 6'h27, 8'h0e - 8'(i)});
    end
    // Divider power and ratio codes, both dividers
    foreach (codes[i]) begin
      wr(8'h2c, {24'h0, codes[i]}, 1'b0);
      wr(8'h30, {24'h0, codes[i] ^ 8'h80}, 1'b0);
      settle();
      check(32'({p1, r1}), 32'({codes[i][7], div_ratio(codes[i][6:0])}));
      check(32'({p2, r2}), 32'({~codes[i][7], div_ratio(codes[i][6:0])}));
      rdc(8'h2c, {24'h0, codes[i]}, 1'b0);
    end
    // Oversampling extremes and an interrupted pair
    HOST.wr_osr(10'h3ff);
    settle();
    check(32'(osr), 32'h3ff);
    HOST.wr_osr(10'h000);
    settle();
    check(32'(osr), 32'h400);
    wr(8'h34, 32'h02, 1'b0);
    settle();
    check(32'(osr), 32'h400);
    wr(8'h2c, 32'h81, 1'b0);
    wr(8'h38, 32'h05, 1'b0);
    settle();
    check(32'(osr), 32'h005);
    rdc(8'h34, 32'h0, 1'b0);
    // Reset again in mid-run
    do_reset();
    rdc(8'h38, 32'h80, 1'b0);
    conclude();
  end
endmodule // tb_acdc_clock_config
